/* File: shared/dcid_params.svh */
// Offsets, field positions, masks and reset values of the identity and capability bank.
// Assumes word (16-bit) addressing of the processor memory bus.
`ifndef DCID_PARAMS_SVH
`define DCID_PARAMS_SVH

// Word addresses of the bank
`define DCID_ADDR_W 16
`define DCID_OFF_CONFIG_LO 16'h0880
`define DCID_OFF_CONFIG_HI 16'h0881
`define DCID_OFF_PART_ID 16'h0882
`define DCID_OFF_SIL_REV 16'h0883
`define DCID_OFF_CAP1_LO 16'h0886
`define DCID_OFF_CAP1_HI 16'h0887
`define DCID_OFF_CAP2_LO 16'h0888
`define DCID_OFF_CAP2_HI 16'h0889
`define DCID_OFF_CAP3_LO 16'h088a
`define DCID_OFF_CAP3_HI 16'h088b

// Capability word one fields
`define DCID_CAP1_PART_NUMBER_FIELD_LSB 22
`define DCID_CAP1_ACCEL_BIT 13
`define DCID_CAP1_RAM_LSB 3
// Capability word two fields
`define DCID_CAP2_CAN_BIT 27
`define DCID_CAP2_QUAD_BIT 16
`define DCID_CAP2_CAPT_BIT 12
`define DCID_CAP2_I2C_BIT 8
`define DCID_CAP2_SPI_BIT 4
`define DCID_CAP2_SER_LSB 0
// Capability word three fields
`define DCID_CAP3_TRIP_LSB 13
`define DCID_CAP3_PWM_LSB 0

// Defined bits of each capability word; all others read zero
`define DCID_CAP1_MASK 32'h3fc0_2078
`define DCID_CAP2_MASK 32'h0801_1117
`define DCID_CAP3_MASK 32'h000f_e07f

// Configuration register
`define DCID_CONFIG_RESET 32'h0000_0000
`define DCID_CONFIG_WMASK 32'h0000_ffff

`endif

/* File: shared/dcid_pkg.sv */
// Types shared by the identity and capability bank.
// Assumes dcid_params.svh for the address width.
`include "dcid_params.svh"

package dcid_pkg;

  // One request of the processor memory bus, taken in a single cycle
  typedef struct packed {
    logic [`DCID_ADDR_W-1:0] addr;
    logic rd;
    logic wr;
    logic wide;
    logic [31:0] wdata;
  } dcid_req_t;

  // Registered answer
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } dcid_resp_t;

  typedef enum logic {
    DCID_LOCKED,
    DCID_UNLOCKED
  } dcid_prot_t;

endpackage

/* File: verilog/dcid_protect.sv */
// Write-protection state driven by the unlock and lock instructions.
// Assumes the instruction strobes are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps

module dcid_protect (
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous, active high
  input wire logic unlock_pulse, // Protect-unlock instruction executed
  input wire logic lock_pulse, // Protect-lock instruction executed
  output logic unlocked // Protected writes allowed
);

  dcid_pkg::dcid_prot_t state_reg;
  dcid_pkg::dcid_prot_t state_next;

  ////////////////////////////////////////////////////////////////////////
  // Lock wins a tie so stray code cannot leave the bank open
  always_comb
  begin
    case (state_reg)
      dcid_pkg::DCID_LOCKED:
        state_next = (unlock_pulse && !lock_pulse) ? dcid_pkg::DCID_UNLOCKED
                                                    : dcid_pkg::DCID_LOCKED;
      dcid_pkg::DCID_UNLOCKED:
        state_next = lock_pulse ? dcid_pkg::DCID_LOCKED : dcid_pkg::DCID_UNLOCKED;
      default:
        state_next = dcid_pkg::DCID_LOCKED;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state_reg <= dcid_pkg::DCID_LOCKED;
    else
      state_reg <= state_next;
  end

  assign unlocked = (state_reg == dcid_pkg::DCID_UNLOCKED);

endmodule

/* File: verilog/dcid_regs.sv */
// Identity and capability register bank on the processor memory bus.
// Assumes single-cycle requests in word addressing, 16- or 32-bit wide,
// and unlock/lock instruction pulses from the processor.
//
// Behaviour
// - Part number in capability word one bits 29:22, mirrored in identity low byte.
// - Word one: bit 13 math accelerator, bits 6:3 RAM blocks 3..0.
// - Word two: CAN 27, quadrature 16, capture 12, I2C 8, SPI 4, serial C/B/A 2:0.
// - Word three bits 19:13 flag comparator trip filters seven down to one.
// - Word three bits 6:0 flag PWM units seven down to one.
// - A zero capability bit means that module is absent.
// - Capability contents fixed per part variant and read only.
// - Reserved capability bits always read zero.
// - Bank at word 0x0880 holds protected configuration, part identity, silicon revision and capability words.
// - Protected registers ignore writes until unlock, blocked again after lock.
// - Both 16-bit and 32-bit accesses are accepted.
`timescale 1ns/1ps
`include "dcid_params.svh"

module dcid_regs #(
  parameter logic [7:0] PART_NUMBER = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_ID_HIGH = 8'h0a, // Arbitrary value
  parameter logic [15:0] SILICON_REV = 16'h0001, // Arbitrary value
  parameter logic MATH_ACCEL_PRESENT = 1'b1,
  parameter logic [3:0] RAM_BLOCKS_PRESENT = 4'hf, // Blocks 3..0
  parameter logic CAN_PRESENT = 1'b1,
  parameter logic QUAD_DECODER_PRESENT = 1'b1,
  parameter logic CAPTURE_UNIT_PRESENT = 1'b1,
  parameter logic I2C_PRESENT = 1'b1,
  parameter logic SPI_PRESENT = 1'b1,
  parameter logic [2:0] SERIAL_PORTS_PRESENT = 3'h7, // Ports C, B, A
  parameter logic [6:0] TRIP_FILTERS_PRESENT = 7'h7f, // Filters 7..1
  parameter logic [6:0] PWM_UNITS_PRESENT = 7'h7f, // Units 7..1
  parameter logic [31:0] CONFIG_WMASK = `DCID_CONFIG_WMASK
) (
  input wire logic clk, // System clock, 20 MHz
  input wire logic reset, // Synchronous, active high
  input wire dcid_pkg::dcid_req_t req, // Bus request
  input wire logic unlock_pulse, // Protect-unlock instruction
  input wire logic lock_pulse, // Protect-lock instruction
  output dcid_pkg::dcid_resp_t resp, // Read answer, one cycle late
  output logic write_ignored, // Pulse: a write hit and was dropped
  output logic unlocked_status, // Protected writes allowed, one cycle late
  output logic [31:0] config_out // Configuration register contents
);

  ////////////////////////////////////////////////////////////////////////
  // Fixed capability words
  wire [31:0] cap1_raw;
  wire [31:0] cap2_raw;
  wire [31:0] cap3_raw;
  wire [31:0] cap1_word;
  wire [31:0] cap2_word;
  wire [31:0] cap3_word;
  wire [15:0] part_id_word;

  // One presence flag per unit; bit n of each field stands for unit n+1
  wire [6:0] trip_filter_present;
  wire [6:0] pwm_unit_present;

  genvar idx;
  generate
    for (idx = 0; idx < 7; idx++)
    begin : g_unit_flag
      assign trip_filter_present[idx] = TRIP_FILTERS_PRESENT[idx];
      assign pwm_unit_present[idx] = PWM_UNITS_PRESENT[idx];
    end
  endgenerate

  assign cap1_raw = (32'(PART_NUMBER) << `DCID_CAP1_PART_NUMBER_FIELD_LSB)
                  | (32'(MATH_ACCEL_PRESENT) << `DCID_CAP1_ACCEL_BIT)
                  | (32'(RAM_BLOCKS_PRESENT) << `DCID_CAP1_RAM_LSB);
  assign cap2_raw = (32'(CAN_PRESENT) << `DCID_CAP2_CAN_BIT)
                  | (32'(QUAD_DECODER_PRESENT) << `DCID_CAP2_QUAD_BIT)
                  | (32'(CAPTURE_UNIT_PRESENT) << `DCID_CAP2_CAPT_BIT)
                  | (32'(I2C_PRESENT) << `DCID_CAP2_I2C_BIT)
                  | (32'(SPI_PRESENT) << `DCID_CAP2_SPI_BIT)
                  | (32'(SERIAL_PORTS_PRESENT) << `DCID_CAP2_SER_LSB);
  assign cap3_raw = (32'(trip_filter_present) << `DCID_CAP3_TRIP_LSB)
                  | (32'(pwm_unit_present) << `DCID_CAP3_PWM_LSB);

  // Absent modules leave their bit clear; reserved bits forced to zero
  assign cap1_word = cap1_raw & `DCID_CAP1_MASK;
  assign cap2_word = cap2_raw & `DCID_CAP2_MASK;
  assign cap3_word = cap3_raw & `DCID_CAP3_MASK;

  // Identity low byte taken from the same field as word one
  assign part_id_word = {PART_ID_HIGH,
                         cap1_word[`DCID_CAP1_PART_NUMBER_FIELD_LSB +: 8]};

  ////////////////////////////////////////////////////////////////////////
  // Protection state
  logic unlocked;

  dcid_protect u_protect (
    .clk(clk),
    .reset(reset),
    .unlock_pulse(unlock_pulse),
    .lock_pulse(lock_pulse),
    .unlocked(unlocked)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read decode, used for both halves of a wide access
  logic [31:0] config_reg;
  logic [31:0] config_next;

  function automatic logic [15:0] read_half(input logic [`DCID_ADDR_W-1:0] a,
                                            input logic [31:0] cfg,
                                            input logic [31:0] c1,
                                            input logic [31:0] c2,
                                            input logic [31:0] c3,
                                            input logic [15:0] pid);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      `DCID_OFF_CONFIG_LO: v = cfg[15:0];
      `DCID_OFF_CONFIG_HI: v = cfg[31:16];
      `DCID_OFF_PART_ID: v = pid;
      `DCID_OFF_SIL_REV: v = SILICON_REV;
      `DCID_OFF_CAP1_LO: v = c1[15:0];
      `DCID_OFF_CAP1_HI: v = c1[31:16];
      `DCID_OFF_CAP2_LO: v = c2[15:0];
      `DCID_OFF_CAP2_HI: v = c2[31:16];
      `DCID_OFF_CAP3_LO: v = c3[15:0];
      `DCID_OFF_CAP3_HI: v = c3[31:16];
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  function automatic logic in_bank(input logic [`DCID_ADDR_W-1:0] a);
    return (a >= `DCID_OFF_CONFIG_LO) && (a <= `DCID_OFF_CAP3_HI);
  endfunction

  // Wide accesses use the even word; the odd word carries the upper half
  wire [`DCID_ADDR_W-1:0] base_addr;
  wire [`DCID_ADDR_W-1:0] upper_addr;
  wire [15:0] low_half;
  wire [15:0] high_half;
  wire [31:0] read_data;

  assign base_addr = req.wide ? {req.addr[`DCID_ADDR_W-1:1], 1'b0} : req.addr;
  assign upper_addr = {req.addr[`DCID_ADDR_W-1:1], 1'b1};
  assign low_half = read_half(base_addr, config_reg, cap1_word, cap2_word, cap3_word,
                              part_id_word);
  assign high_half = read_half(upper_addr, config_reg, cap1_word, cap2_word, cap3_word,
                               part_id_word);
  assign read_data = req.wide ? {high_half, low_half} : {16'h0000, low_half};

  ////////////////////////////////////////////////////////////////////////
  // Write decode
  wire hit_cfg_lo;
  wire hit_cfg_hi;
  wire cfg_write_ok;
  wire hit_bank;
  wire dropped;
  wire [31:0] half_sel;
  wire [31:0] wr_value;

  assign hit_cfg_lo = req.wr && (base_addr == `DCID_OFF_CONFIG_LO);
  assign hit_cfg_hi = req.wr && (req.wide ? (base_addr == `DCID_OFF_CONFIG_LO)
                                          : (req.addr == `DCID_OFF_CONFIG_HI));
  assign cfg_write_ok = unlocked && (hit_cfg_lo || hit_cfg_hi);
  assign hit_bank = req.wr && (in_bank(base_addr) || (req.wide && in_bank(upper_addr)));

  // Any write into the bank that does not land in the config register is dropped,
  // including capability, identity and revision words while unlocked
  assign dropped = hit_bank && !cfg_write_ok;

  // A narrow write to the upper half arrives on the low data lanes
  assign half_sel = {{16{hit_cfg_hi}}, {16{hit_cfg_lo}}};
  assign wr_value = (req.wide || hit_cfg_lo) ? req.wdata : {req.wdata[15:0], 16'h0000};

  // Only writable config bits move; the rest keep their value
  assign config_next = cfg_write_ok
                     ? ((config_reg & ~(half_sel & CONFIG_WMASK))
                        | (wr_value & half_sel & CONFIG_WMASK))
                     : config_reg;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk)
  begin
    if (reset)
      config_reg <= `DCID_CONFIG_RESET;
    else
      config_reg <= config_next;
  end

  // Idle answer lanes stay at zero so a bus that ORs its slaves sees nothing
  wire [31:0] resp_data_next;

  assign resp_data_next = req.rd ? read_data : 32'h0000_0000;

  always_ff @(posedge clk)
  begin
    if (reset)
      resp <= '0;
    else
      resp <= {req.rd, resp_data_next};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      write_ignored <= 1'b0;
    else
      write_ignored <= dropped;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      unlocked_status <= 1'b0;
    else
      unlocked_status <= unlocked;
  end

  assign config_out = config_reg;

endmodule

/* File: sim/dcid_regs_checker.sv */
// Port assertions for the identity and capability bank.
// Assumes it is bound onto dcid_regs, single clock domain.
`timescale 1ns/1ps
`include "dcid_params.svh"

module dcid_regs_checker (
  input wire logic clk, // Clock
  input wire logic reset, // Sync reset
  input wire dcid_pkg::dcid_req_t req, // Bus request
  input wire logic unlock_pulse, // Unlock instruction
  input wire logic lock_pulse, // Lock instruction
  input wire dcid_pkg::dcid_resp_t resp, // Read answer
  input wire logic write_ignored, // Drop pulse
  input wire logic unlocked_status, // Protection state
  input wire logic [31:0] config_out // Config contents
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire cfg_wr = req.wr && req.addr[15:1] == 15'h0440;
  wire id_wr = req.wr && req.addr[15:1] == 15'h0441;
  wire cap_wr = req.wr && req.addr >= 16'h0886 && req.addr <= 16'h088b;
  ////////////////////////////////////////
  chk_read_answer: assert property (req.rd |=> resp.valid)
    else $error("read not answered");
  chk_no_answer: assert property (!req.rd |=> !resp.valid)
    else $error("answer without read");
  chk_idle_zero: assert property (!resp.valid |-> resp.data == 32'h0)
    else $error("data while idle");
  chk_cap_ro: assert property (cap_wr |=> write_ignored)
    else $error("capability write kept");
  chk_id_ro: assert property (id_wr |=> write_ignored)
    else $error("identity write kept");
  chk_cfg_hold: assert property (!cfg_wr |=> $stable(config_out))
    else $error("config changed without write");
  chk_lock_block: assert property (lock_pulse ##1 cfg_wr |=> write_ignored)
    else $error("write passed after lock");
  chk_unlock_write: assert property (unlock_pulse && !lock_pulse ##1 cfg_wr && req.wide
    |=> !write_ignored ##1 config_out[15:0] == $past(req.wdata[15:0], 2))
    else $error("unlocked write lost");
  chk_status_lag: assert property (unlock_pulse && !lock_pulse ##1 !lock_pulse
    |=> unlocked_status)
    else $error("status not unlocked");
  chk_reserved_zero: assert property (req.rd && req.wide && req.addr[15:1] == 15'h0443
    |=> (resp.data & ~`DCID_CAP1_MASK) == 32'h0)
    else $error("reserved bit set");
  cov_read: cover property (req.rd && req.wide ##1 resp.valid);
  cov_drop: cover property (cap_wr ##1 write_ignored);
  cov_unlock: cover property (unlock_pulse ##1 cfg_wr);
endmodule

bind dcid_regs dcid_regs_checker u_dcid_regs_checker (.clk(clk), .reset(reset), .req(req),
  .unlock_pulse(unlock_pulse), .lock_pulse(lock_pulse), .resp(resp),
  .write_ignored(write_ignored), .unlocked_status(unlocked_status), .config_out(config_out));

/* File: sim/dcid_regs_tb.sv */
// Self-checking bench for the identity and capability bank.
// Assumes the checker file is compiled alongside for the bind.
`timescale 1ns/1ps

module dcid_regs_tb;
  logic clk, reset, unlock_pulse, lock_pulse, write_ignored, unlocked_status;
  logic [31:0] config_out;
  dcid_pkg::dcid_req_t req;
  dcid_pkg::dcid_resp_t resp;
  int error_cnt = 0;
  int checks = 0;

  // Mixed presence so absent units show as zero bits
  dcid_regs #(.RAM_BLOCKS_PRESENT(4'h5), .CAN_PRESENT(1'b0), .TRIP_FILTERS_PRESENT(7'h2a),
    .PWM_UNITS_PRESENT(7'h15)) u_dcid_regs (.clk(clk), .reset(reset), .req(req),
    .unlock_pulse(unlock_pulse), .lock_pulse(lock_pulse), .resp(resp),
    .write_ignored(write_ignored), .unlocked_status(unlocked_status), .config_out(config_out));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
    checks++;
  endtask

  task automatic end_sim();
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic rd(input logic [15:0] a, input logic w, input logic [31:0] exp);
    req.addr = a;
    req.wide = w;
    req.rd = 1'b1;
    @(posedge clk);
    #1;
    req.rd = 1'b0;
    chk({31'h0, resp.valid}, 32'h1);
    chk(resp.data, exp);
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic w, input logic [31:0] d, input logic ign);
    req.addr = a;
    req.wide = w;
    req.wdata = d;
    req.wr = 1'b1;
    @(posedge clk);
    #1;
    req.wr = 1'b0;
    chk({31'h0, write_ignored}, {31'h0, ign});
    @(posedge clk);
    #1;
  endtask

  task automatic pulse(input logic unlock);
    unlock_pulse = unlock;
    lock_pulse = !unlock;
    @(posedge clk);
    #1;
    unlock_pulse = 1'b0;
    lock_pulse = 1'b0;
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    chk(config_out, 32'h0);
    chk({31'h0, unlocked_status}, 32'h0);
  endtask

  task automatic t_caps();
    rd(16'h0886, 1'b1, 32'h1680_2028);
    rd(16'h0888, 1'b1, 32'h0001_1117);
    rd(16'h088a, 1'b1, 32'h0005_4015);
    rd(16'h088b, 1'b0, 32'h0000_0005);
    rd(16'h088a, 1'b0, 32'h0000_4015);
    rd(16'h0887, 1'b0, 32'h0000_1680);
    rd(16'h0882, 1'b0, 32'h0000_0a5a);
    rd(16'h0883, 1'b0, 32'h0000_0001);
    rd(16'h0884, 1'b0, 32'h0000_0000);
  endtask

  task automatic t_protect();
    wr(16'h0880, 1'b1, 32'hdead_beef, 1'b1);
    chk(config_out, 32'h0);
    pulse(1'b1);
    wr(16'h0880, 1'b1, 32'hdead_beef, 1'b0);
    @(posedge clk);
    #1;
    chk(config_out, 32'h0000_beef);
    chk({31'h0, unlocked_status}, 32'h1);
    wr(16'h0881, 1'b0, 32'h0000_ffff, 1'b0);
    chk(config_out, 32'h0000_beef);
    // Capability writes send zero, so reserved bits match the read; the identity write sends ffff
    wr(16'h0886, 1'b1, 32'h0000_0000, 1'b1);
    wr(16'h088b, 1'b0, 32'h0000_0000, 1'b1);
    wr(16'h0882, 1'b0, 32'h0000_ffff, 1'b1);
    rd(16'h0886, 1'b1, 32'h1680_2028);
    rd(16'h088a, 1'b1, 32'h0005_4015);
    pulse(1'b0);
    wr(16'h0880, 1'b1, 32'h0000_1234, 1'b1);
    @(posedge clk);
    #1;
    chk(config_out, 32'h0000_beef);
    chk({31'h0, unlocked_status}, 32'h0);
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    #100000;
    error_cnt++;
    end_sim();
  end

  initial
  begin
    req = '0;
    unlock_pulse = 1'b0;
    lock_pulse = 1'b0;
    reset = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_caps();
    t_protect();
    end_sim();
  end
endmodule
